// file: analog_function_power_regs.sv
// register bank for regulator voltage and analog channel/power control
`timescale 1ns/1ps
`include "analog_power_cfg.svh"
module analog_function_power_regs
  import analog_power_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PAIRS = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  // register access port
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  output logic acc_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic rd_hit,
  // reference supply pin
  input wire logic external_reference_input,
  // status
  output logic code_prohibited,
  output logic reference_conflict,
  // analog control levels
  output logic [3:0] regulator_code,
  output logic regulator_enable,
  output logic converter_enable,
  output logic amplifier_enable,
  output logic temp_sensor_enable,
  output logic [PAIRS-1:0] amp_pair_route,
  output logic amp_input_open
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] target);
    addr_is = (a == ADDR_W'(target));
  endfunction : addr_is

  logic hit_voltage, hit_power;
  logic hit_any;

  assign hit_voltage = addr_is(acc_addr, `REG_VOLTAGE_ADDR);
  assign hit_power = addr_is(acc_addr, `REG_POWER_ADDR);
  assign hit_any = hit_voltage || hit_power;

  // ----------------------------------------------------------------
  // stored registers
  // ----------------------------------------------------------------
  logic [7:0] regulator_voltage_select_reg, regulator_voltage_select_next;
  logic [7:0] channel_select_power_control_reg, channel_select_power_control_next;
  logic wr_take;

  // a frozen edge loads no register, so the strobe needs no enable term
  assign wr_take = acc_valid && acc_write;

  always_comb begin
    regulator_voltage_select_next = regulator_voltage_select_reg;
    channel_select_power_control_next = channel_select_power_control_reg;
    if (wr_take) begin
      // whole byte stored, upper voltage bits kept only for readback
      if (hit_voltage) begin
        regulator_voltage_select_next = acc_wdata;
      end
      if (hit_power) begin
        channel_select_power_control_next = acc_wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regulator_voltage_select_reg <= `REG_VOLTAGE_RESET;
      channel_select_power_control_reg <= `REG_POWER_RESET;
    end else if (clock_en) begin
      regulator_voltage_select_reg <= regulator_voltage_select_next;
      channel_select_power_control_reg <= channel_select_power_control_next;
    end
  end

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  access_state_t state_reg, state_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic rd_hit_reg, rd_hit_next;
  logic rd_take;

  // unmapped addresses answer zero, never a stale byte
  function automatic logic [7:0] read_mux(input logic sel_v, input logic sel_p, input logic [7:0] vb,
    input logic [7:0] pb);
    if (sel_v) begin
      read_mux = vb;
    end else if (sel_p) begin
      read_mux = pb;
    end else begin
      read_mux = 8'h00;
    end
  endfunction : read_mux

  assign rd_take = acc_valid && !acc_write;

  always_comb begin
    state_next = acc_idle;
    rd_data_next = rd_data_reg;
    rd_hit_next = rd_hit_reg;
    unique case (state_reg)
      acc_idle, acc_answer: begin
        if (rd_take) begin
          state_next = acc_answer;
          rd_hit_next = hit_any;
          rd_data_next = read_mux(hit_voltage, hit_power, regulator_voltage_select_reg,
            channel_select_power_control_reg);
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= acc_idle;
      rd_data_reg <= 8'h00;
      rd_hit_reg <= 1'b0;
    end else if (clock_en) begin
      state_reg <= state_next;
      rd_data_reg <= rd_data_next;
      rd_hit_reg <= rd_hit_next;
    end
  end

  // a request is taken on any enabled edge, so ready follows the enable
  assign acc_ready = clock_en;
  assign rd_valid = (state_reg == acc_answer);
  assign rd_data = rd_data_reg;
  assign rd_hit = rd_hit_reg;

  // ----------------------------------------------------------------
  // reference pin synchroniser and status
  // ----------------------------------------------------------------
  logic ref_meta_reg, ref_meta_next;
  logic ref_sync_reg, ref_sync_next;
  logic prohibited_reg, prohibited_next;
  logic conflict_reg, conflict_next;

  // pin is asynchronous: only the second stage reads the first
  always_comb begin
    ref_meta_next = external_reference_input;
    ref_sync_next = ref_meta_reg;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ref_meta_reg <= 1'b0;
      ref_sync_reg <= 1'b0;
    end else if (clock_en) begin
      ref_meta_reg <= ref_meta_next;
      ref_sync_reg <= ref_sync_next;
    end
  end

  always_comb begin
    // flags are levels: they show the present setting, no clear needed
    prohibited_next = regulator_voltage_select_reg[`VOLT_CODE_HI:`VOLT_CODE_LO] > `VOLT_CODE_MAX;
    // converter must not fight an externally driven reference
    conflict_next = ref_sync_reg && channel_select_power_control_reg[`PWR_CONV_BIT];
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prohibited_reg <= 1'b0;
      conflict_reg <= 1'b0;
    end else if (clock_en) begin
      prohibited_reg <= prohibited_next;
      conflict_reg <= conflict_next;
    end
  end

  assign code_prohibited = prohibited_reg;
  assign reference_conflict = conflict_reg;

  // ----------------------------------------------------------------
  // analog control decode
  // ----------------------------------------------------------------
  // levels are registered again, so they lag the stored byte by one edge
  power_ctrl_if ctrl ();

  assign ctrl.voltage_byte = regulator_voltage_select_reg;
  assign ctrl.power_byte = channel_select_power_control_reg;

  power_ctrl_decode #(
    .PAIRS(PAIRS)
  ) u_decode (
    .clock(clock),
    .resetn(resetn),
    .clock_en(clock_en),
    .ctrl(ctrl.decode),
    .regulator_code(regulator_code),
    .regulator_enable(regulator_enable),
    .converter_enable(converter_enable),
    .amplifier_enable(amplifier_enable),
    .temp_sensor_enable(temp_sensor_enable),
    .amp_pair_route(amp_pair_route),
    .amp_input_open(amp_input_open)
  );

endmodule : analog_function_power_regs

// file: analog_power_cfg.svh
// offsets, field positions and reset values of the analog power register bank
`ifndef ANALOG_POWER_CFG_SVH
`define ANALOG_POWER_CFG_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define REG_VOLTAGE_ADDR 8'h02
`define REG_POWER_ADDR 8'h04

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define REG_VOLTAGE_RESET 8'h00
`define REG_POWER_RESET 8'h00

// ----------------------------------------------------------------
// regulator voltage select fields
// ----------------------------------------------------------------
`define VOLT_CODE_HI 3
`define VOLT_CODE_LO 0
`define VOLT_CODE_MAX 4'hd

// ----------------------------------------------------------------
// channel select and power control fields
// ----------------------------------------------------------------
`define PWR_MUX_HI 7
`define PWR_MUX_LO 6
`define PWR_AMP_BIT 3
`define PWR_CONV_BIT 2
`define PWR_REG_BIT 1
`define PWR_TEMP_BIT 0

`endif

// file: analog_power_pkg.sv
// types shared by the analog power register bank
package analog_power_pkg;

  // ----------------------------------------------------------------
  // amplifier input selection codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    amp_in_pair0 = 2'h0,
    amp_in_pair1 = 2'h1,
    amp_in_pair2 = 2'h2,
    amp_in_open = 2'h3
  } amp_input_t;

  // ----------------------------------------------------------------
  // access port state
  // ----------------------------------------------------------------
  typedef enum logic {
    acc_idle,
    acc_answer
  } access_state_t;

endpackage : analog_power_pkg

// file: power_ctrl_if.sv
// stored control bytes passed from the register bank to the control decoder
`timescale 1ns/1ps
interface power_ctrl_if;
  logic [7:0] voltage_byte;
  logic [7:0] power_byte;

  modport bank (output voltage_byte, output power_byte);
  modport decode (input voltage_byte, input power_byte);
endinterface : power_ctrl_if

// file: power_ctrl_decode.sv
// turns the stored control bytes into registered analog control levels
`timescale 1ns/1ps
`include "analog_power_cfg.svh"
module power_ctrl_decode
  import analog_power_pkg::*;
#(
  parameter int PAIRS = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  // stored bytes
  power_ctrl_if.decode ctrl,
  // analog control levels
  output logic [3:0] regulator_code,
  output logic regulator_enable,
  output logic converter_enable,
  output logic amplifier_enable,
  output logic temp_sensor_enable,
  output logic [PAIRS-1:0] amp_pair_route,
  output logic amp_input_open
);

  logic [3:0] code_reg, code_next;
  logic [3:0] en_reg, en_next;
  logic [PAIRS-1:0] route_reg, route_next;
  logic open_reg, open_next;
  amp_input_t sel;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  // upper nibble of the voltage byte is ignored here
  assign code_next = ctrl.voltage_byte[`VOLT_CODE_HI:`VOLT_CODE_LO];
  assign sel = amp_input_t'({ctrl.power_byte[`PWR_MUX_HI], ctrl.power_byte[`PWR_MUX_LO]});
  assign en_next = {ctrl.power_byte[`PWR_AMP_BIT],
                    ctrl.power_byte[`PWR_CONV_BIT],
                    ctrl.power_byte[`PWR_REG_BIT],
                    ctrl.power_byte[`PWR_TEMP_BIT]};
  assign open_next = (sel == amp_in_open);

  genvar i;
  generate
    for (i = 0; i < PAIRS; i++) begin : g_route
      assign route_next[i] = (sel == amp_input_t'(i));
    end
  endgenerate

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      code_reg <= 4'h0;
      en_reg <= 4'h0;
      route_reg <= '0;
      open_reg <= 1'b0;
    end else if (clock_en) begin
      code_reg <= code_next;
      en_reg <= en_next;
      route_reg <= route_next;
      open_reg <= open_next;
    end
  end

  assign regulator_code = code_reg;
  assign amplifier_enable = en_reg[3];
  assign converter_enable = en_reg[2];
  assign regulator_enable = en_reg[1];
  assign temp_sensor_enable = en_reg[0];
  assign amp_pair_route = route_reg;
  assign amp_input_open = open_reg;

endmodule : power_ctrl_decode

// file: power_regs_asserts.sv
// checker watching the analog power register bank ports
`timescale 1ns/1ps
module power_regs_checker #(
  parameter int ADDR_W = 8,
  parameter int PAIRS = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  // access port
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit,
  // analog levels
  input wire logic [3:0] regulator_code,
  input wire logic regulator_enable,
  input wire logic converter_enable,
  input wire logic amplifier_enable,
  input wire logic temp_sensor_enable,
  input wire logic [PAIRS-1:0] amp_pair_route,
  input wire logic amp_input_open
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // accesses taken
  // ----------------------------------------
  // levels land two enabled edges after the write
  sequence s_pwr_wr;
    clock_en && acc_valid && acc_write && acc_addr == 8'h04 ##1 clock_en;
  endsequence
  sequence s_vlt_wr;
    clock_en && acc_valid && acc_write && acc_addr == 8'h02 ##1 clock_en;
  endsequence
  sequence s_rd;
    clock_en && acc_valid && !acc_write;
  endsequence
  property p_temp; s_pwr_wr |=> temp_sensor_enable == $past(acc_wdata[0], 2); endproperty
  property p_regen; s_pwr_wr |=> regulator_enable == $past(acc_wdata[1], 2); endproperty
  property p_conv; s_pwr_wr |=> converter_enable == $past(acc_wdata[2], 2); endproperty
  property p_amp; s_pwr_wr |=> amplifier_enable == $past(acc_wdata[3], 2); endproperty
  property p_route; s_pwr_wr |=> {amp_input_open, amp_pair_route} == (4'h1 << $past(acc_wdata[7:6], 2)); endproperty
  property p_code; s_vlt_wr |=> regulator_code == $past(acc_wdata[3:0], 2); endproperty
  property p_rd; s_rd |=> rd_valid; endproperty
  property p_rd_cause; rd_valid && $past(clock_en) |-> $past(clock_en && acc_valid && !acc_write); endproperty
  property p_unmapped;
    clock_en && acc_valid && !acc_write && acc_addr != 8'h02 && acc_addr != 8'h04 |=> rd_data == 8'h00 && !rd_hit;
  endproperty
  a_temp: assert property (p_temp) else $error("sensor enable wrong");
  a_regen: assert property (p_regen) else $error("regulator enable wrong");
  a_conv: assert property (p_conv) else $error("converter enable wrong");
  a_amp: assert property (p_amp) else $error("amplifier enable wrong");
  a_route: assert property (p_route) else $error("input route wrong");
  a_code: assert property (p_code) else $error("regulator code wrong");
  a_rd: assert property (p_rd) else $error("read answer missing");
  a_rd_cause: assert property (p_rd_cause) else $error("read answer without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not empty");
endmodule : power_regs_checker

bind analog_function_power_regs power_regs_checker #(.ADDR_W(ADDR_W), .PAIRS(PAIRS)) i_chk (
  .clock(clock), .resetn(resetn), .clock_en(clock_en), .acc_valid(acc_valid), .acc_write(acc_write),
  .acc_addr(acc_addr), .acc_wdata(acc_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .rd_hit(rd_hit),
  .regulator_code(regulator_code), .regulator_enable(regulator_enable), .converter_enable(converter_enable),
  .amplifier_enable(amplifier_enable), .temp_sensor_enable(temp_sensor_enable),
  .amp_pair_route(amp_pair_route), .amp_input_open(amp_input_open));

// file: host_model.sv
// host model driving the register port and the reference pin
`timescale 1ns/1ps
module host_model (
  // clock and ready
  input wire logic clock,
  input wire logic acc_ready,
  // request
  output logic acc_valid,
  output logic acc_write,
  output logic [7:0] acc_addr,
  output logic [7:0] acc_wdata,
  // reference pin
  output logic external_reference_input
);
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr = 8'h00;
    acc_wdata = 8'h00;
    external_reference_input = 1'b0;
  end
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    if (wr && a == 8'h02 && d[3:0] > 4'hd) d[3:0] = 4'hd;
    if (wr && a == 8'h04 && external_reference_input) d[2] = 1'b0;
    acc_valid = 1'b1;
    acc_write = wr;
    acc_addr = a;
    acc_wdata = d;
    @(posedge clock);
    while (acc_ready !== 1'b1) @(posedge clock);
    #1;
    // released lines flip so no stale value looks valid
    acc_valid = 1'b0;
    acc_addr = ~a;
    acc_wdata = ~d;
    // one idle edge, so valid never drops and rises in one time step
    @(posedge clock);
    #1;
  endtask : access
  task automatic set_ref(input logic v);
    external_reference_input = v;
  endtask : set_ref
endmodule : host_model

// file: tb.sv
// self-checking bench for the analog power register bank
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clock_en = 1'b1;
  logic acc_valid, acc_write, acc_ready, rd_valid, rd_hit, ext_ref, code_prohibited, reference_conflict;
  logic [7:0] acc_addr, acc_wdata, rd_data, v, p;
  logic [3:0] regulator_code;
  logic regulator_enable, converter_enable, amplifier_enable, temp_sensor_enable, amp_input_open;
  logic [2:0] amp_pair_route;
  logic [8:0] exp_q[$];
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h7422;
  int i;
  always #50 clock = ~clock;
  host_model i_host (.clock(clock), .acc_ready(acc_ready), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .external_reference_input(ext_ref));
  analog_function_power_regs i_dut (.clock(clock), .resetn(resetn), .clock_en(clock_en),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_ready(acc_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_hit(rd_hit),
    .external_reference_input(ext_ref), .code_prohibited(code_prohibited),
    .reference_conflict(reference_conflict), .regulator_code(regulator_code),
    .regulator_enable(regulator_enable), .converter_enable(converter_enable),
    .amplifier_enable(amplifier_enable), .temp_sensor_enable(temp_sensor_enable),
    .amp_pair_route(amp_pair_route), .amp_input_open(amp_input_open));
  // ----------------------------------------
  // compares and report
  // ----------------------------------------
  task automatic cmp(input string what, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic check_levels(input logic [7:0] vb, input logic [7:0] pb);
    cmp("levels", {vb[3:0], 4'h1 << pb[7:6], pb[3:0]}, {regulator_code, amp_input_open, amp_pair_route,
      amplifier_enable, converter_enable, regulator_enable, temp_sensor_enable});
  endtask : check_levels
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // read answers in order against the noted expectations
  always @(negedge clock) begin
    // a frozen edge holds the answer, so it counts once, before an enabled edge
    if (rd_valid === 1'b1 && clock_en === 1'b1) begin
      if (exp_q.size() == 0) cmp("read extra", 12'h000, 12'h1ff);
      else cmp("read", {3'h0, exp_q.pop_front()}, {3'h0, rd_hit, rd_data});
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      $display("timeout");
      final_report;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.access(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    i_host.access(1'b0, a, 8'h00);
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask : settle
  task automatic reset_and_check;
    resetn = 1'b0;
    repeat (3) @(posedge clock);
    #1 resetn = 1'b1;
    rd(8'h02, 9'h100);
    rd(8'h04, 9'h100);
    settle;
    check_levels(8'h00, 8'h00);
  endtask : reset_and_check
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_and_check;
    $display("test reset done");
    for (i = 0; i < 14; i++) begin
      v = 8'($random(seed));
      v[3:0] = i[3:0];
      wr(8'h02, v);
      settle;
      check_levels(v, 8'h00);
      cmp("prohibited", 12'h000, {11'h000, code_prohibited});
      rd(8'h02, {1'b1, v});
    end
    $display("test voltage done");
    for (i = 0; i < 16; i++) begin
      p = 8'($random(seed));
      p[7:6] = i[1:0];
      wr(8'h04, p);
      settle;
      check_levels(v, p);
      rd(8'h04, {1'b1, p});
      rd(8'h80 | 8'($random(seed)), 9'h000);
    end
    $display("test power done");
    clock_en = 1'b0;
    fork
      wr(8'h04, 8'h0f);
    join_none
    repeat (4) @(posedge clock);
    #1 check_levels(v, p);
    cmp("ready frozen", 12'h000, {11'h000, acc_ready});
    clock_en = 1'b1;
    wait fork;
    settle;
    check_levels(v, 8'h0f);
    $display("test freeze done");
    i_host.set_ref(1'b1);
    wr(8'h04, 8'hff);
    repeat (4) @(posedge clock);
    #1 check_levels(v, 8'hfb);
    cmp("conflict", 12'h000, {11'h000, reference_conflict});
    i_host.set_ref(1'b0);
    settle;
    $display("test reference done");
    reset_and_check;
    $display("test second reset done");
    settle;
    cmp("reads pending", 12'h000, 12'(exp_q.size()));
    final_report;
  end
endmodule : tb
